// ### hw/sml_master_link.v
// Master link controller: host port, transmitter, receiver and return FIFO
`timescale 1ns/1ps
`default_nettype none
`include "sml_consts.vh"

// Operation
// - Every frame is fifteen bits: start, address, flag, byte, parity, stop.
// - Each bit, the stop bit too, lasts one ten microsecond period.
// - At least four microseconds of idle line between frames.
// - The serial line rests high when no frame is sent.
// - Frames start low; three start-bit samples reject glitches.
// - Address zero reaches all devices; one to seven are single devices.
// - Flag one means the byte is an opcode, zero means data.
// - Transmitted parity makes the count of ones in the frame odd.
// - An even count of ones in a received frame is a parity error.
// - A low received stop bit is a framing error.
// - One serial output toward the loop, one serial input back.
// - Separate eight-bit buses carry bytes to and from the host.
// - Returned frames are kept in a sixteen-frame FIFO.
// - Host writes of header then payload send a formatted frame.
// - One master and up to seven slaves on the loop.
// - Reading the payload register pops one FIFO entry.
// - Each received bit is the majority of three samples.
// - Interrupt the host when the command returns or a framing or parity error arrives while it is outstanding.
module sml_master_link #(
   parameter integer BIT_CYC    = `SML_BIT_CYC,
   parameter integer GAP_CYC    = `SML_GAP_CYC,
   parameter integer RESYNC_CYC = `SML_RESYNC_CYC
) (
   input  wire       core_clk,    // Core clock, 40 MHz
   input  wire       reset_n,     // Synchronous reset, active low
   input  wire [1:0] host_addr,   // Host register select
   input  wire       host_wr,     // Host write strobe
   input  wire       host_rd,     // Host read strobe
   input  wire [7:0] host_wdata,  // Host write bus
   output reg  [7:0] host_rdata,  // Host read bus
   output reg        host_irq,    // Interrupt to host, active high
   input  wire       ser_in,      // Serial input from loop
   output wire       ser_out      // Serial output to loop
);

   localparam [2:0]  RX_IDLE   = 3'b001;
   localparam [2:0]  RX_BIT    = 3'b010;
   localparam [2:0]  RX_RESYNC = 3'b100;
   localparam [15:0] BIT_LAST  = BIT_CYC[15:0] - 16'h1;
   localparam [15:0] SMP1      = BIT_CYC[17:2];
   localparam [15:0] SMP2      = BIT_CYC[16:1];
   localparam [15:0] SMP3      = SMP1 + SMP2;
   localparam [15:0] RS_LAST   = RESYNC_CYC[15:0] - 16'h1;
   localparam integer DEPTH    = `SML_FIFO_DEPTH;

   // Odd count of ones over a vector of frame fields
   function odd12;
      input [11:0] v;
      begin
         odd12 = ^v;
      end
   endfunction

   // Best of three samples
   function maj3;
      input [2:0] s;
      begin
         maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
      end
   endfunction

   // Host header, transmit status
   reg  [3:0]  hdr_q;
   reg         await_q;
   wire        tx_busy;
   wire        tx_start;
   wire [14:0] tx_frame;
   wire        tx_par;

   // Receiver state
   reg        sin_m_q;
   reg        sin_s_q;
   reg [2:0]  rx_state_q;
   reg [15:0] rx_cnt_q;
   reg [3:0]  rx_bit_q;
   reg [2:0]  smp_q;
   reg [13:0] rx_shift_q;
   wire       rx_end;
   wire       rx_val;
   wire       rx_last;
   wire [14:0] rx_frame;
   wire       ev_glitch;
   wire       ev_ferr;
   wire       ev_perr;
   wire       ev_good;

   // Error flags
   reg        ovf_q;
   reg        ferr_q;
   reg        perr_q;

   // Buffer and FIFO
   wire        buf_in_ready;
   wire        buf_out_valid;
   wire [11:0] buf_out_data;
   wire        fifo_push;
   wire        fifo_pop;
   wire        fifo_full;
   reg  [11:0] fifo_mem [0:DEPTH-1];
   reg  [3:0]  wr_ptr_q;
   reg  [3:0]  rd_ptr_q;
   reg  [4:0]  fifo_cnt_q;
   wire [11:0] fifo_top;
   wire        fifo_nonempty;

   // Host access decode
   wire rd_payload;
   wire rd_header;
   wire rd_error;
   wire rd_irq;
   wire wr_payload;
   wire wr_header;

   assign rd_payload = host_rd & (host_addr == `SML_A_PAYLOAD);
   assign rd_header  = host_rd & (host_addr == `SML_A_HEADER);
   assign rd_error   = host_rd & (host_addr == `SML_A_ERROR);
   assign rd_irq     = host_rd & (host_addr == `SML_A_IRQ);
   assign wr_payload = host_wr & (host_addr == `SML_A_PAYLOAD);
   assign wr_header  = host_wr & (host_addr == `SML_A_HEADER);

   // Frame assembly from header and payload byte
   // Start and stop add one 1, so parity is the XOR of the twelve fields
   assign tx_par   = odd12({hdr_q[2:0], hdr_q[3], host_wdata[7:0]});
   assign tx_frame = {1'b0, hdr_q[2:0], hdr_q[3], host_wdata, tx_par, 1'b1};
   assign tx_start = wr_payload & ~tx_busy;

   // Header register, written before the payload
   always @(posedge core_clk) begin
      if (!reset_n) begin
         hdr_q <= `SML_HDR_RST;
      end else if (wr_header) begin
         hdr_q <= {host_wdata[`SML_HDR_CMD], host_wdata[`SML_HDR_ADDR_HI:`SML_HDR_ADDR_LO]};
      end
   end

   sml_tx_shifter #(
      .BIT_CYC (BIT_CYC),
      .GAP_CYC (GAP_CYC)
   ) u_tx (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .start    (tx_start),
      .frame    (tx_frame),
      .ser_out  (ser_out),
      .busy     (tx_busy)
   );

   // Input synchroniser
   always @(posedge core_clk) begin
      if (!reset_n) begin
         sin_m_q <= 1'b1;
         sin_s_q <= 1'b1;
      end else begin
         sin_m_q <= ser_in;
         sin_s_q <= sin_m_q;
      end
   end

   // Receive event decode at the end of each bit period
   assign rx_end    = (rx_state_q == RX_BIT) & (rx_cnt_q == BIT_LAST);
   assign rx_val    = maj3(smp_q);
   assign rx_last   = (rx_bit_q == 4'he);
   assign rx_frame  = {rx_shift_q, rx_val};
   assign ev_glitch = rx_end & (rx_bit_q == 4'h0) & rx_val;
   assign ev_ferr   = rx_end & rx_last & ~rx_val;
   assign ev_perr   = rx_end & rx_last & rx_val
                      & ~(odd12(rx_frame[13:2]) ^ rx_frame[1] ^ 1'b1);
   assign ev_good   = rx_end & rx_last & rx_val & ~ev_perr;

   // Receive sequencer with three samples per bit and resync on framing error
   always @(posedge core_clk) begin
      if (!reset_n) begin
         rx_state_q <= RX_IDLE;
         rx_cnt_q   <= 16'h0000;
         rx_bit_q   <= 4'h0;
         smp_q      <= 3'h7;
         rx_shift_q <= 14'h0000;
      end else begin
         case (rx_state_q)
            RX_IDLE: begin
               rx_cnt_q <= 16'h0000;
               rx_bit_q <= 4'h0;
               if (!sin_s_q) begin
                  rx_state_q <= RX_BIT;
               end
            end
            RX_BIT: begin
               if (rx_cnt_q == SMP1) begin
                  smp_q[0] <= sin_s_q;
               end
               if (rx_cnt_q == SMP2) begin
                  smp_q[1] <= sin_s_q;
               end
               if (rx_cnt_q == SMP3) begin
                  smp_q[2] <= sin_s_q;
               end
               if (rx_end) begin
                  rx_cnt_q   <= 16'h0000;
                  rx_bit_q   <= rx_bit_q + 4'h1;
                  rx_shift_q <= {rx_shift_q[12:0], rx_val};
                  if (ev_glitch) begin
                     rx_state_q <= RX_IDLE;
                  end else if (ev_ferr) begin
                     rx_state_q <= RX_RESYNC;
                  end else if (rx_last) begin
                     rx_state_q <= RX_IDLE;
                  end
               end else begin
                  rx_cnt_q <= rx_cnt_q + 16'h1;
               end
            end
            RX_RESYNC: begin
               if (!sin_s_q) begin
                  rx_cnt_q <= 16'h0000;
               end else if (rx_cnt_q == RS_LAST) begin
                  rx_state_q <= RX_IDLE;
               end else begin
                  rx_cnt_q <= rx_cnt_q + 16'h1;
               end
            end
            default: begin
               rx_state_q <= RX_IDLE;
            end
         endcase
      end
   end

   // Two-entry stage between receiver and FIFO, absorbs a full FIFO
   sml_buf2 #(
      .WIDTH (12)
   ) u_buf (
      .core_clk  (core_clk),
      .reset_n   (reset_n),
      .in_valid  (ev_good),
      .in_ready  (buf_in_ready),
      .in_data   (rx_frame[13:2]),
      .out_valid (buf_out_valid),
      .out_ready (~fifo_full),
      .out_data  (buf_out_data)
   );

   // Return FIFO, top entry is what the host reads
   assign fifo_full     = (fifo_cnt_q == DEPTH[4:0]);
   assign fifo_nonempty = (fifo_cnt_q != 5'h00);
   assign fifo_push     = buf_out_valid & ~fifo_full;
   assign fifo_pop      = rd_payload & fifo_nonempty;
   assign fifo_top      = fifo_nonempty ? fifo_mem[rd_ptr_q] : 12'h000;

   always @(posedge core_clk) begin
      if (!reset_n) begin
         wr_ptr_q   <= 4'h0;
         rd_ptr_q   <= 4'h0;
         fifo_cnt_q <= 5'h00;
      end else begin
         if (fifo_push) begin
            fifo_mem[wr_ptr_q] <= buf_out_data;
            wr_ptr_q           <= wr_ptr_q + 4'h1;
         end
         if (fifo_pop) begin
            rd_ptr_q <= rd_ptr_q + 4'h1;
         end
         if (fifo_push && !fifo_pop) begin
            fifo_cnt_q <= fifo_cnt_q + 5'h01;
         end else if (fifo_pop && !fifo_push) begin
            fifo_cnt_q <= fifo_cnt_q - 5'h01;
         end
      end
   end

   // Error flags, a new event wins over the clearing read
   always @(posedge core_clk) begin
      if (!reset_n) begin
         ovf_q  <= 1'b0;
         ferr_q <= 1'b0;
         perr_q <= 1'b0;
      end else begin
         ovf_q  <= (ovf_q & ~rd_error) | (ev_good & fifo_full);
         ferr_q <= (ferr_q & ~rd_error) | (ev_ferr & await_q);
         perr_q <= (perr_q & ~rd_error) | (ev_perr & await_q);
      end
   end

   // Command outstanding and interrupt; set wins over the clearing read
   always @(posedge core_clk) begin
      if (!reset_n) begin
         await_q  <= 1'b0;
         host_irq <= 1'b0;
      end else begin
         if (tx_start && hdr_q[3]) begin
            await_q <= 1'b1;
         end else if ((ev_good && rx_frame[`SML_FR_CMD]) || ((ev_ferr || ev_perr) && await_q)) begin
            await_q <= 1'b0;
         end
         host_irq <= (host_irq & ~rd_irq)
                     | (ev_good & rx_frame[`SML_FR_CMD])
                     | ((ev_ferr | ev_perr) & await_q);
      end
   end

   // Read bus, loaded on each read strobe
   always @(posedge core_clk) begin
      if (!reset_n) begin
         host_rdata <= `SML_RDATA_RST;
      end else if (host_rd) begin
         case (host_addr)
            `SML_A_PAYLOAD: host_rdata <= fifo_top[7:0];
            `SML_A_HEADER:  host_rdata <= {tx_busy, fifo_nonempty, 2'h0, fifo_top[8],
                                           fifo_top[11:9]};
            `SML_A_ERROR:   host_rdata <= {5'h00, ovf_q, ferr_q, perr_q};
            `SML_A_IRQ:     host_rdata <= {7'h00, host_irq};
            default:        host_rdata <= `SML_RDATA_RST;
         endcase
      end
   end

endmodule // sml_master_link

`default_nettype wire

// ### hw/sml_consts.vh
// Constants for the serial loop master link: timing, host map and frame fields
`ifndef SML_CONSTS_VH
`define SML_CONSTS_VH

// Core clock rate and link timing in their own units
`define SML_CLK_MHZ        40
`define SML_BIT_NS         10000
`define SML_GAP_NS         4000
`define SML_RESYNC_NS      150000

// Derived cycle counts: bit period exact, gap and resync rounded up
`define SML_BIT_CYC        ((`SML_BIT_NS * `SML_CLK_MHZ) / 1000)
`define SML_GAP_CYC        ((`SML_GAP_NS * `SML_CLK_MHZ + 999) / 1000)
`define SML_RESYNC_CYC     ((`SML_RESYNC_NS * `SML_CLK_MHZ + 999) / 1000)

// Frame geometry, first bit on the wire is bit 14
`define SML_FRAME_BITS     15
`define SML_FR_START       14
`define SML_FR_ADDR_HI     13
`define SML_FR_ADDR_LO     11
`define SML_FR_CMD         10
`define SML_FR_DATA_HI     9
`define SML_FR_DATA_LO     2
`define SML_FR_PAR         1
`define SML_FR_STOP        0
`define SML_ADDR_ALL       3'h0

// Return buffer depth in frames
`define SML_FIFO_DEPTH     16

// Host port addresses
`define SML_A_PAYLOAD      2'h0
`define SML_A_HEADER       2'h1
`define SML_A_ERROR        2'h2
`define SML_A_IRQ          2'h3

// Header byte fields
`define SML_HDR_BUSY       7
`define SML_HDR_NONEMPTY   6
`define SML_HDR_CMD        3
`define SML_HDR_ADDR_HI    2
`define SML_HDR_ADDR_LO    0

// Error byte fields
`define SML_ERR_OVF        2
`define SML_ERR_FRM        1
`define SML_ERR_PAR        0

// Reset values
`define SML_HDR_RST        4'h0
`define SML_RDATA_RST      8'h00

`endif

// ### hw/sml_buf2.v
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none

module sml_buf2 #(
   parameter integer WIDTH = 12
) (
   input  wire             core_clk,  // Core clock
   input  wire             reset_n,   // Synchronous reset, active low
   input  wire             in_valid,  // Word offered
   output wire             in_ready,  // Room for a word
   input  wire [WIDTH-1:0] in_data,   // Offered word
   output wire             out_valid, // Word held
   input  wire             out_ready, // Sink takes word
   output wire [WIDTH-1:0] out_data   // Oldest word
);

   reg [WIDTH-1:0] mem_q [0:1];
   reg             wr_q;
   reg             rd_q;
   reg [1:0]       cnt_q;
   wire            push;
   wire            pop;

   // Handshake terms
   assign in_ready  = (cnt_q != 2'h2);
   assign out_valid = (cnt_q != 2'h0);
   assign out_data  = mem_q[rd_q];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   // Storage and pointers
   always @(posedge core_clk) begin
      if (!reset_n) begin
         wr_q  <= 1'b0;
         rd_q  <= 1'b0;
         cnt_q <= 2'h0;
      end else begin
         if (push) begin
            mem_q[wr_q] <= in_data;
            wr_q        <= ~wr_q;
         end
         if (pop) begin
            rd_q <= ~rd_q;
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + 2'h1;
         end else if (pop && !push) begin
            cnt_q <= cnt_q - 2'h1;
         end
      end
   end

endmodule // sml_buf2

`default_nettype wire

// ### hw/sml_tx_shifter.v
// Serial frame transmitter with bit timing and inter-frame gap
`timescale 1ns/1ps
`default_nettype none
`include "sml_consts.vh"

module sml_tx_shifter #(
   parameter integer BIT_CYC = `SML_BIT_CYC,
   parameter integer GAP_CYC = `SML_GAP_CYC
) (
   input  wire        core_clk, // Core clock
   input  wire        reset_n,  // Synchronous reset, active low
   input  wire        start,    // One-cycle start, ignored while busy
   input  wire [14:0] frame,    // Frame, bit 14 first
   output reg         ser_out,  // Serial output to loop
   output wire        busy      // Shifting or in gap
);

   localparam [2:0] ST_IDLE  = 3'b001;
   localparam [2:0] ST_SHIFT = 3'b010;
   localparam [2:0] ST_GAP   = 3'b100;
   localparam [15:0] BIT_LAST = BIT_CYC[15:0] - 16'h1;
   localparam [15:0] GAP_LAST = GAP_CYC[15:0] - 16'h1;

   reg [2:0]  state_q;
   reg [14:0] shift_q;
   reg [3:0]  bit_q;
   reg [15:0] cnt_q;

   assign busy = (state_q != ST_IDLE);

   // Shift sequencer
   always @(posedge core_clk) begin
      if (!reset_n) begin
         state_q <= ST_IDLE;
         shift_q <= 15'h7fff;
         bit_q   <= 4'h0;
         cnt_q   <= 16'h0000;
         ser_out <= 1'b1;
      end else begin
         case (state_q)
            ST_IDLE: begin
               ser_out <= 1'b1;
               if (start) begin
                  shift_q <= frame;
                  bit_q   <= 4'h0;
                  cnt_q   <= 16'h0000;
                  ser_out <= frame[14];
                  state_q <= ST_SHIFT;
               end
            end
            ST_SHIFT: begin
               if (cnt_q == BIT_LAST) begin
                  cnt_q <= 16'h0000;
                  if (bit_q == 4'he) begin
                     ser_out <= 1'b1;
                     state_q <= ST_GAP;
                  end else begin
                     bit_q   <= bit_q + 4'h1;
                     shift_q <= {shift_q[13:0], 1'b1};
                     ser_out <= shift_q[13];
                  end
               end else begin
                  cnt_q <= cnt_q + 16'h1;
               end
            end
            ST_GAP: begin
               if (cnt_q == GAP_LAST) begin
                  state_q <= ST_IDLE;
               end else begin
                  cnt_q <= cnt_q + 16'h1;
               end
            end
            default: begin
               state_q <= ST_IDLE;
               ser_out <= 1'b1;
            end
         endcase
      end
   end

endmodule // sml_tx_shifter

`default_nettype wire

// ### dv/sml_master_link_asserts.sv
// Port checks for the serial loop master link
`timescale 1ns/1ps
`default_nettype none

module sml_master_link_asserts #(
   parameter integer BIT_CYC    = 400,
   parameter integer GAP_CYC    = 160,
   parameter integer RESYNC_CYC = 6000
) (
   input wire logic       core_clk,   // Core clock
   input wire logic       reset_n,    // Reset, active low
   input wire logic [1:0] host_addr,  // Register select
   input wire logic       host_wr,    // Write strobe
   input wire logic       host_rd,    // Read strobe
   input wire logic [7:0] host_wdata, // Write bus
   input wire logic [7:0] host_rdata, // Read bus
   input wire logic       host_irq,   // Interrupt
   input wire logic       ser_in,     // Loop input
   input wire logic       ser_out     // Loop output
);
   localparam integer FRAME_CYC = 15 * BIT_CYC;
   logic        in_frame_q; // Outgoing frame under way
   integer      cyc_q;      // Cycle within the frame
   integer      idle_q;     // High cycles since last frame, saturating
   logic [14:0] bits_q;     // Mid-bit samples

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   // Follow each outgoing frame
   always @(posedge core_clk) begin
      if (!reset_n) begin
         in_frame_q <= 1'b0;
         cyc_q      <= 0;
         idle_q     <= GAP_CYC;
         bits_q     <= 15'h0000;
      end else if (!in_frame_q) begin
         in_frame_q <= !ser_out;
         cyc_q      <= 1;
         if (ser_out && idle_q < GAP_CYC)
            idle_q <= idle_q + 1;
      end else begin
         cyc_q <= cyc_q + 1;
         if (cyc_q % BIT_CYC == BIT_CYC / 2)
            bits_q <= {bits_q[13:0], ser_out};
         if (cyc_q == FRAME_CYC - 1) begin
            in_frame_q <= 1'b0;
            idle_q     <= 0;
         end
      end
   end

   property p_start_low; in_frame_q && cyc_q < BIT_CYC |-> !ser_out; endproperty
   a_start_low: assert property (p_start_low) else $error("start bit not low");
   property p_stop_high; in_frame_q && cyc_q >= 14 * BIT_CYC |-> ser_out; endproperty
   a_stop_high: assert property (p_stop_high) else $error("stop bit not high");
   property p_bit_hold; in_frame_q && cyc_q % BIT_CYC != 0 |-> $stable(ser_out); endproperty
   a_bit_hold: assert property (p_bit_hold) else $error("bit changed mid period");
   property p_parity; in_frame_q && cyc_q == FRAME_CYC - 1 |-> ^bits_q; endproperty
   a_parity: assert property (p_parity) else $error("frame ones count even");
   property p_gap; !in_frame_q && !ser_out |-> idle_q >= GAP_CYC; endproperty
   a_gap: assert property (p_gap) else $error("idle gap too short");
   property p_rdata_hold; !host_rd |=> $stable(host_rdata); endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
   property p_irq_read; host_rd && host_addr == 2'h3 |=> host_rdata == {7'h00, $past(host_irq)}; endproperty
   a_irq_read: assert property (p_irq_read) else $error("irq read wrong");
   property p_irq_sticky; $fell(host_irq) |-> $past(host_rd && host_addr == 2'h3); endproperty
   a_irq_sticky: assert property (p_irq_sticky) else $error("irq dropped unread");

   // Main scenarios
   c_frame: cover property (in_frame_q && cyc_q == FRAME_CYC - 1);
   c_irq: cover property ($rose(host_irq));
   c_overflow: cover property (host_rd && host_addr == 2'h2 ##1 host_rdata[2]);
endmodule // sml_master_link_asserts

bind sml_master_link sml_master_link_asserts #(
   .BIT_CYC(BIT_CYC), .GAP_CYC(GAP_CYC), .RESYNC_CYC(RESYNC_CYC)
) i_asserts (
   .core_clk(core_clk), .reset_n(reset_n), .host_addr(host_addr), .host_wr(host_wr),
   .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata),
   .host_irq(host_irq), .ser_in(ser_in), .ser_out(ser_out)
);

`default_nettype wire

// ### dv/sml_loop_model.sv
// Behavioural loop of slave controllers in loop-back mode
`timescale 1ns/1ps
`default_nettype none

module sml_loop_model #(
   parameter integer BIT_CYC = 16,
   parameter integer GAP_CYC = 4
) (
   input  wire logic core_clk, // Core clock
   input  wire logic rx,       // Frames from the master
   output var  logic tx        // Frames back to the master
);
   logic [14:0] last_rx;  // Last frame heard
   integer      rx_count; // Frames heard
   logic        loop_en;  // Return frames when set
   integer      delay;    // Cycles before returning
   integer      corrupt;  // 1 bad parity, 2 low stop

   // Idle line and defaults
   initial begin
      tx       = 1'b1;
      rx_count = 0;
      loop_en  = 1'b1;
      delay    = 0;
      corrupt  = 0;
   end

   // Shift a frame out, bit 14 first, then idle high
   task automatic send(input logic [14:0] f);
      for (int i = 14; i >= 0; i--) begin
         @(posedge core_clk);
         #1 tx = f[i];
         repeat (BIT_CYC - 1) @(posedge core_clk);
      end
      @(posedge core_clk);
      #1 tx = 1'b1;
      repeat (GAP_CYC) @(posedge core_clk);
   endtask

   // Short low pulse that must not pass for a frame
   task automatic glitch(input integer n);
      @(posedge core_clk);
      #1 tx = 1'b0;
      repeat (n) @(posedge core_clk);
      #1 tx = 1'b1;
   endtask

   // Hear each frame mid-bit, then hand it back
   always begin : rx_proc
      logic [14:0] f;
      @(negedge rx);
      repeat (BIT_CYC / 2) @(posedge core_clk);
      for (int i = 14; i >= 0; i--) begin
         f[i] = rx;
         if (i > 0)
            repeat (BIT_CYC) @(posedge core_clk);
      end
      last_rx  = f;
      rx_count = rx_count + 1;
      if (loop_en) begin
         repeat (delay) @(posedge core_clk);
         send(corrupt == 1 ? f ^ 15'h0002 : corrupt == 2 ? f ^ 15'h0003 : f);
      end
   end
endmodule // sml_loop_model

`default_nettype wire

// ### dv/tb_sml_master_link.sv
// Self-checking bench for the serial loop master link
`timescale 1ns/1ps
`default_nettype none

module tb_sml_master_link;
   localparam integer BIT_CYC = 16;
   localparam integer GAP_CYC = 4;
   logic       core_clk;   // Core clock
   logic       reset_n;    // Reset, active low
   logic [1:0] host_addr;  // Register select
   logic       host_wr;    // Write strobe
   logic       host_rd;    // Read strobe
   logic [7:0] host_wdata; // Write bus
   wire  [7:0] host_rdata; // Read bus
   wire        host_irq;   // Interrupt
   wire        ser_in;     // Loop to master
   wire        ser_out;    // Master to loop
   integer     n_errors;   // Mismatches
   integer     n_compared; // Comparisons
   logic [7:0] rv;         // Last value read

   sml_master_link #(.BIT_CYC(BIT_CYC), .GAP_CYC(GAP_CYC), .RESYNC_CYC(20)) i_dut (
      .core_clk(core_clk), .reset_n(reset_n), .host_addr(host_addr), .host_wr(host_wr),
      .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata),
      .host_irq(host_irq), .ser_in(ser_in), .ser_out(ser_out));
   sml_loop_model #(.BIT_CYC(BIT_CYC), .GAP_CYC(GAP_CYC)) i_model (
      .core_clk(core_clk), .rx(ser_out), .tx(ser_in));

   // 40 MHz clock
   always #12.5 core_clk = ~core_clk;

   // Compare and count
   task automatic check(input logic [14:0] seen, input logic [14:0] exp, input string what);
      n_compared = n_compared + 1;
      if (seen !== exp) begin
         n_errors = n_errors + 1;
         $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   // Counts, verdict, end of run
   task automatic conclude;
      $display("compared %0d wrong %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // One host write
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge core_clk);
      #1 {host_wr, host_addr, host_wdata} = {1'b1, a, d};
      @(posedge core_clk);
      #1 host_wr = 1'b0;
   endtask

   // One host read into rv
   task automatic rd(input logic [1:0] a);
      @(posedge core_clk);
      #1 {host_rd, host_addr} = {1'b1, a};
      @(posedge core_clk);
      #1 host_rd = 1'b0;
      @(posedge core_clk);
      #1 rv = host_rdata;
   endtask

   // Expected frame with odd ones count
   function automatic logic [14:0] mk(input logic [2:0] a, input logic c, input logic [7:0] d);
      return {1'b0, a, c, d, ^{a, c, d}, 1'b1};
   endfunction

   // Bounded waits
   task automatic wait_rx(input integer n);
      for (int k = 0; k < 4000 && i_model.rx_count < n; k++) @(posedge core_clk);
      check(i_model.rx_count, n, "frames on loop");
   endtask
   task automatic wait_fifo;
      rd(2'h1);
      for (int k = 0; k < 400 && rv[6] !== 1'b1; k++) rd(2'h1);
   endtask

   // Reset state
   task automatic t_reset;
      check(ser_out, 1'b1, "idle line");
      for (int a = 0; a < 4; a++) begin
         rd(a[1:0]);
         check(rv, 8'h00, "reset value");
      end
   endtask

   // Every address, both kinds, prompt and slow return
   task automatic t_loop;
      logic [7:0] d;
      integer     n;
      for (int i = 0; i < 8; i++) begin
         d = i[0] ? ~(8'(i) << 5) : 8'(i) << 5;
         i_model.delay = i[1] ? 300 : 0;
         n = i_model.rx_count;
         wr(2'h1, {4'h0, i[0], i[2:0]});
         wr(2'h0, d);
         wait_rx(n + 1);
         check(i_model.last_rx, mk(i[2:0], i[0], d), "frame sent");
         wait_fifo;
         check(rv, {4'h4, i[0], i[2:0]}, "returned header");
         rd(2'h0);
         check(rv, d, "returned payload");
         rd(2'h3);
         check(rv, {7'h00, i[0]}, "irq on return");
      end
   endtask

   // Bad parity unasked, glitch, then errors on a command
   task automatic t_errors;
      i_model.send(mk(3'h2, 1'b0, 8'h44) ^ 15'h0002);
      i_model.glitch(3);
      repeat (20 * BIT_CYC) @(posedge core_clk);
      rd(2'h2);
      check(rv, 8'h00, "error without command");
      for (int e = 1; e < 3; e++) begin
         i_model.corrupt = e;
         wr(2'h1, 8'h0b);
         wr(2'h0, 8'h96);
         for (int k = 0; k < 2000 && host_irq !== 1'b1; k++) @(posedge core_clk);
         rd(2'h2);
         check(rv, 8'(e), "error flags");
         rd(2'h3);
         check(rv, 8'h01, "irq on error");
         repeat (4 * BIT_CYC) @(posedge core_clk);
      end
      i_model.corrupt = 0;
      rd(2'h1);
      check(rv, 8'h00, "nothing stored");
   endtask

   // Payload while shifting dropped, header kept
   task automatic t_busy;
      integer n;
      n = i_model.rx_count;
      i_model.loop_en = 1'b0;
      wr(2'h1, 8'h0e);
      @(posedge core_clk);
      #1 {host_wr, host_addr, host_wdata} = {1'b1, 2'h0, 8'h3c};
      @(posedge core_clk);
      #1 host_wdata = 8'hc3;
      @(posedge core_clk);
      #1 host_wr = 1'b0;
      rd(2'h1);
      check(rv[7], 1'b1, "busy flag");
      wait_rx(n + 1);
      check(i_model.last_rx, mk(3'h6, 1'b1, 8'h3c), "first payload");
      for (int k = 0; k < 400 && rv[7] !== 1'b0; k++) rd(2'h1);
      wr(2'h0, 8'h7e);
      wait_rx(n + 2);
      check(i_model.last_rx, mk(3'h6, 1'b1, 8'h7e), "header kept");
   endtask

   // Seventeen frames into sixteen places, read back in order
   task automatic t_overflow;
      for (int i = 0; i < 17; i++)
         i_model.send(mk(i[2:0], 1'b0, 8'(i)));
      rd(2'h2);
      check(rv, 8'h04, "overflow");
      for (int i = 0; i < 17; i++) begin
         rd(2'h1);
         check(rv, {5'h08, i[2:0]}, "stored header");
         rd(2'h0);
         check(rv, 8'(i), "stored payload");
      end
      rd(2'h0);
      check(rv, 8'h00, "empty pop");
   endtask

   // Reset, scenarios, verdict
   initial begin
      {core_clk, reset_n, host_wr, host_rd, host_addr, host_wdata} = 14'h0000;
      n_errors = 0;
      n_compared = 0;
      rv = 8'h00;
      repeat (16) @(posedge core_clk);
      #1 reset_n = 1'b1;
      t_reset;
      t_loop;
      t_errors;
      t_busy;
      t_overflow;
      conclude;
   end

   // Watchdog
   initial begin
      repeat (60000) @(posedge core_clk);
      n_errors = n_errors + 1;
      $display("wrong value at %0t: watchdog expired", $time);
      conclude;
   end
endmodule // tb_sml_master_link

`default_nettype wire
